/* File: rtl/su_defs.svh */
`ifndef SU_DEFS_SVH
`define SU_DEFS_SVH

// Register addresses on the special function bus
`define SU_ADDR_CTRL   8'h98
`define SU_ADDR_DATA   8'h99

// Control register field positions
`define SU_BIT_MODE    7
`define SU_BIT_ONE     6
`define SU_BIT_MCE     5
`define SU_BIT_REN     4
`define SU_BIT_TB8     3
`define SU_BIT_RB8     2
`define SU_BIT_TI      1
`define SU_BIT_RI      0
`define SU_CTRL_RESET  8'h40

// Timer clock source codes and prescaler limits (count minus one)
`define SU_CSEL_SYS    3'h0
`define SU_CSEL_DIV4   3'h1
`define SU_CSEL_DIV12  3'h2
`define SU_CSEL_DIV48  3'h3
`define SU_CSEL_EXT8   3'h4
`define SU_LIM_DIV4    6'h03
`define SU_LIM_DIV12   6'h0b
`define SU_LIM_DIV48   6'h2f
`define SU_LIM_EXT8    3'h7
`define SU_TMR_TOP     8'hff

// Transmit buffer shape
`define SU_FIFO_WIDTH  8
`define SU_FIFO_DEPTH  32
`define SU_FIFO_AW     5
`endif

/* File: rtl/su_pkg.sv */
`include "su_defs.svh"
package su_pkg;
  typedef enum logic [1:0] {SU_TX_IDLE, SU_TX_DATA, SU_TX_STOP} su_tx_e;
  typedef enum logic [1:0] {SU_RX_IDLE, SU_RX_START, SU_RX_DATA,
                            SU_RX_STOP} su_rx_e;

  // CPU register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } su_cpu_s;

  // Shared timer configuration
  typedef struct packed {
    logic       run;
    logic [2:0] clk_sel;
    logic [7:0] reload;
  } su_tmr_s;

  // Control register bits held in hardware
  typedef struct packed {
    logic mode;
    logic mce;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
  } su_ctrl_s;
endpackage

/* File: rtl/su_uart.sv */
`include "su_defs.svh"

// Transmit byte buffer, valid and ready on both sides
module su_fifo #(
  parameter int WIDTH = `SU_FIFO_WIDTH,
  parameter int DEPTH = `SU_FIFO_DEPTH,
  parameter int AW    = `SU_FIFO_AW
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  import su_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        full;
    logic                        rdy;  // Registered so tx_ready is a flop
  } su_fifo_s;

  su_fifo_s s;
  su_fifo_s next_s;
  logic     push;
  logic     pop;

  // Pointer, count and flag update
  always_comb begin
    next_s = s;
    push = in_valid && !s.full;
    pop = out_ready && (s.cnt != '0);
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.full = (next_s.cnt == (AW+1)'(DEPTH));
    next_s.rdy  = !next_s.full;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.rdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready  = s.rdy;
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
endmodule

// Serial port with control and data buffer registers
module su_uart (
  input  wire logic           mclk,
  input  wire logic           rstn,
  input  wire su_pkg::su_cpu_s cpu,
  input  wire su_pkg::su_tmr_s tmr,
  input  wire logic           ext_osc_clk,
  input  wire logic           serial_receive_pin,
  output logic                serial_transmit_pin,
  output logic [7:0]          rdata,
  output logic                irq_req,
  output logic                tx_ready
);
  import su_pkg::*;

  typedef struct packed {
    // Software-visible registers and outputs
    su_ctrl_s   ctrl;
    logic [7:0] rbuf;
    logic [7:0] rdata;
    logic       irq;
    logic       txd;
    // Pin synchronisers and edge history
    logic       rx_s1;
    logic       rx_s2;
    logic       rx_prev;
    logic       ex_s1;
    logic       ex_s2;
    logic       ex_prev;
    // Prescaler and the two 8-bit timers
    logic [5:0] pre;
    logic [2:0] ex_cnt;
    logic [7:0] txt;
    logic [7:0] rxt;
    logic       txph;
    logic       rxph;
    // Transmit shifter
    su_tx_e     txst;
    logic [8:0] txsh;
    logic [3:0] txcnt;
    // Receive shifter
    su_rx_e     rxst;
    logic [8:0] rxsh;
    logic [3:0] rxcnt;
  } su_state_s;

  su_state_s  s;
  su_state_s  next_s;
  logic       tick;
  logic       tx_ovf;
  logic       rx_ovf;
  logic       tx_bit;
  logic       rx_smp;
  logic       start_det;
  logic       ninth;
  logic       accept;
  logic       set_ti;
  logic       set_ri;
  logic       wr_ctrl;
  logic       wr_data;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       fifo_take;
  logic [3:0] nbits;
  logic [1:0] sel;

  // Prescaler limit for the selected internal source
  function automatic logic [5:0] pre_lim(input logic [2:0] sel);
    case (sel)
      `SU_CSEL_DIV4:  pre_lim = `SU_LIM_DIV4;
      `SU_CSEL_DIV12: pre_lim = `SU_LIM_DIV12;
      `SU_CSEL_DIV48: pre_lim = `SU_LIM_DIV48;
      default:        pre_lim = 6'h00;
    endcase
  endfunction

  // Bus address to register select, bit 0 control, bit 1 data
  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    case (addr)
      `SU_ADDR_CTRL: reg_sel = 2'b01;
      `SU_ADDR_DATA: reg_sel = 2'b10;
      default:       reg_sel = 2'b00;
    endcase
  endfunction

  // Write strobes for the two mapped registers
  assign sel     = reg_sel(cpu.addr);
  assign wr_ctrl = cpu.wr && sel[0];
  assign wr_data = cpu.wr && sel[1];

  // Written bytes queue for the transmitter
  su_fifo #(
    .WIDTH (`SU_FIFO_WIDTH),
    .DEPTH (`SU_FIFO_DEPTH),
    .AW    (`SU_FIFO_AW)
  ) u_txq (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (wr_data),
    .in_data   (cpu.wdata),
    .in_ready  (tx_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_take)
  );

  // Timer clock enable from the selected source
  always_comb begin
    tick = 1'b0;
    if (tmr.run) begin
      if (tmr.clk_sel == `SU_CSEL_EXT8) begin
        tick = s.ex_s2 && !s.ex_prev && (s.ex_cnt == `SU_LIM_EXT8);
      end else begin
        tick = (s.pre == pre_lim(tmr.clk_sel));
      end
    end
  end

  // Overflows of both 8-bit timers and the halved bit strobes
  assign tx_ovf    = tick && (s.txt == `SU_TMR_TOP);
  assign rx_ovf    = tick && (s.rxt == `SU_TMR_TOP);
  assign tx_bit    = tx_ovf && s.txph;
  assign rx_smp    = rx_ovf && !s.rxph;
  assign start_det = (s.rxst == SU_RX_IDLE) && s.ctrl.ren
                     && s.rx_prev && !s.rx_s2;
  assign nbits     = s.ctrl.mode ? 4'h9 : 4'h8;
  assign fifo_take = ((s.txst == SU_TX_IDLE) || (s.txst == SU_TX_STOP))
                     && tx_bit && fifo_out_valid;

  // Ninth field and acceptance decided at the stop sample
  always_comb begin
    ninth = s.ctrl.mode ? s.rxsh[8] : s.rx_s2;
    accept = !s.ctrl.ri && (!s.ctrl.mce || ninth);
  end

  // Next state of the whole port
  always_comb begin
    next_s = s;
    set_ti = 1'b0;
    set_ri = 1'b0;

    // Pin synchronisers and edge history
    next_s.rx_s1   = serial_receive_pin;
    next_s.rx_s2   = s.rx_s1;
    next_s.rx_prev = s.rx_s2;
    next_s.ex_s1   = ext_osc_clk;
    next_s.ex_s2   = s.ex_s1;
    next_s.ex_prev = s.ex_s2;

    // Prescalers
    if (!tmr.run || tick || (tmr.clk_sel == `SU_CSEL_EXT8)) begin
      next_s.pre = 6'h00;
    end else begin
      next_s.pre = s.pre + 6'h01;
    end
    if (s.ex_s2 && !s.ex_prev) begin
      next_s.ex_cnt = s.ex_cnt + 3'h1;
    end

    // Transmit timer with auto-reload
    if (tx_ovf) begin
      next_s.txt  = tmr.reload;
      next_s.txph = !s.txph;
    end else if (tick) begin
      next_s.txt = s.txt + 8'h01;
    end

    // Receive timer copy, realigned on a start edge
    if (start_det) begin
      next_s.rxt  = tmr.reload;
      next_s.rxph = 1'b0;
    end else if (rx_ovf) begin
      next_s.rxt  = tmr.reload;
      next_s.rxph = !s.rxph;
    end else if (tick) begin
      next_s.rxt = s.rxt + 8'h01;
    end

    // Transmitter
    case (s.txst)
      SU_TX_IDLE: begin
        next_s.txd = 1'b1;
        if (fifo_take) begin
          next_s.txd   = 1'b0;
          next_s.txsh  = {s.ctrl.tb8, fifo_out_data};
          next_s.txcnt = 4'h0;
          next_s.txst  = SU_TX_DATA;
        end
      end
      SU_TX_DATA: begin
        if (tx_bit) begin
          if (s.txcnt == nbits) begin
            next_s.txd  = 1'b1;
            next_s.txst = SU_TX_STOP;
            set_ti      = 1'b1;
          end else begin
            next_s.txd   = s.txsh[0];
            next_s.txsh  = {1'b0, s.txsh[8:1]};
            next_s.txcnt = s.txcnt + 4'h1;
          end
        end
      end
      SU_TX_STOP: begin
        if (fifo_take) begin
          // A queued byte follows after exactly one stop bit
          next_s.txd   = 1'b0;
          next_s.txsh  = {s.ctrl.tb8, fifo_out_data};
          next_s.txcnt = 4'h0;
          next_s.txst  = SU_TX_DATA;
        end else if (tx_bit) begin
          next_s.txst = SU_TX_IDLE;
        end
      end
      default: next_s.txst = SU_TX_IDLE;
    endcase

    // Receiver, sampling at bit centres
    if (!s.ctrl.ren) begin
      next_s.rxst = SU_RX_IDLE;
    end else begin
      case (s.rxst)
        SU_RX_IDLE: begin
          if (start_det) begin
            next_s.rxst = SU_RX_START;
          end
        end
        SU_RX_START: begin
          if (rx_smp) begin
            next_s.rxcnt = 4'h0;
            next_s.rxst = s.rx_s2 ? SU_RX_IDLE : SU_RX_DATA;
          end
        end
        SU_RX_DATA: begin
          if (rx_smp) begin
            next_s.rxsh[s.rxcnt] = s.rx_s2;
            next_s.rxcnt = s.rxcnt + 4'h1;
            if (s.rxcnt == nbits - 4'h1) begin
              next_s.rxst = SU_RX_STOP;
            end
          end
        end
        SU_RX_STOP: begin
          if (rx_smp) begin
            next_s.rxst = SU_RX_IDLE;
            if (accept) begin
              next_s.rbuf     = s.rxsh[7:0];
              next_s.ctrl.rb8 = ninth;
              set_ri          = 1'b1;
            end
          end
        end
        default: next_s.rxst = SU_RX_IDLE;
      endcase
    end

    // Control writes; hardware set wins over a software clear
    if (wr_ctrl) begin
      next_s.ctrl.mode = cpu.wdata[`SU_BIT_MODE];
      next_s.ctrl.mce  = cpu.wdata[`SU_BIT_MCE];
      next_s.ctrl.ren  = cpu.wdata[`SU_BIT_REN];
      next_s.ctrl.tb8  = cpu.wdata[`SU_BIT_TB8];
      next_s.ctrl.ti   = cpu.wdata[`SU_BIT_TI];
      next_s.ctrl.ri   = cpu.wdata[`SU_BIT_RI];
      if (!set_ri) begin
        next_s.ctrl.rb8 = cpu.wdata[`SU_BIT_RB8];
      end
    end
    if (set_ti) begin
      next_s.ctrl.ti = 1'b1;
    end
    if (set_ri) begin
      next_s.ctrl.ri = 1'b1;
    end
    next_s.irq = next_s.ctrl.ti || next_s.ctrl.ri;

    // Register reads
    if (cpu.rd) begin
      if (sel[0]) begin
        next_s.rdata = {s.ctrl.mode, 1'b1, s.ctrl.mce, s.ctrl.ren,
                        s.ctrl.tb8, s.ctrl.rb8, s.ctrl.ti, s.ctrl.ri};
      end else if (sel[1]) begin
        next_s.rdata = s.rbuf;
      end else begin
        next_s.rdata = 8'h00;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s         <= '0;
      s.txd     <= 1'b1;
      s.rx_s1   <= 1'b1;
      s.rx_s2   <= 1'b1;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign serial_transmit_pin = s.txd;
  assign rdata               = s.rdata;
  assign irq_req             = s.irq;
endmodule

/* File: bench/su_uart_props.sv */
module su_uart_props (
  input wire logic            mclk,
  input wire logic            rstn,
  input wire su_pkg::su_cpu_s cpu,
  input wire su_pkg::su_tmr_s tmr,
  input wire logic            ext_osc_clk,
  input wire logic            serial_receive_pin,
  input wire logic            serial_transmit_pin,
  input wire logic [7:0]      rdata,
  input wire logic            irq_req,
  input wire logic            tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  import su_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Decoded register strobes
  logic rd_c;
  logic wr_c;
  logic wr_d;
  logic fast;
  logic [7:0] last_c;
  assign rd_c = cpu.rd && cpu.addr == 8'h98;
  assign wr_c = cpu.wr && cpu.addr == 8'h98;
  assign wr_d = cpu.wr && cpu.addr == 8'h99;
  assign fast = tmr.run && tmr.clk_sel == 3'h0 && tmr.reload == 8'hfe;
  // Last control byte written, for the read-back check
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_c <= 8'h40;
    end else if (wr_c) begin
      last_c <= cpu.wdata;
    end
  end

  a_bit6_one: assert property (rd_c |=> rdata[6])
    else $error("control bit 6 read as zero");
  a_unmapped_zero: assert property (cpu.rd && cpu.addr != 8'h98
    && cpu.addr != 8'h99 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!cpu.rd |=> $stable(rdata))
    else $error("read data changed without a read");
  a_ctrl_readback: assert property (rd_c |=>
    rdata[7] == $past(last_c[7])
    && rdata[5:4] == $past(last_c[5:4]))
    else $error("control bits not read back");
  a_bit_len: assert property ($changed(serial_transmit_pin) && fast
    |=> $stable(serial_transmit_pin)[*3])
    else $error("transmit bit shorter than four cycles");
  a_flag_stays: assert property (irq_req && !wr_c && !$past(wr_c)
    |=> irq_req)
    else $error("done flag cleared without software");
  a_ready_drop: assert property ($fell(tx_ready) |->
    $past(wr_d) || $past(wr_d, 2))
    else $error("buffer full without a data write");
  a_reset_idle: assert property ($rose(rstn) |->
    serial_transmit_pin && tx_ready && !irq_req)
    else $error("outputs not idle after reset");
endmodule

bind su_uart su_uart_props u_props (.mclk, .rstn, .cpu, .tmr, .ext_osc_clk,
  .serial_receive_pin, .serial_transmit_pin, .rdata, .irq_req, .tx_ready);

/* File: bench/su_remote.sv */
module su_remote (
  input  wire logic mclk,
  input  wire logic serial_transmit_pin,
  output logic      serial_receive_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bit length in clock cycles, set by the bench per timer source
  int         bit_len = 4;
  logic       nine;
  logic [8:0] got;
  int         got_cnt;
  initial begin
    nine = 1'b0;
    got = 9'h000;
    got_cnt = 0;
    serial_receive_pin = 1'b1;
  end
  // Start, bits v[0..n] with v[n] as stop, then one idle bit time
  task automatic send(input logic [9:0] v, input int n);
    for (int i = -1; i <= n + 1; i++) begin
      @(posedge mclk);
      #1 serial_receive_pin = (i < 0) ? 1'b0 : (i > n) ? 1'b1 : v[i];
      repeat (bit_len - 1) @(posedge mclk);
    end
  endtask
  // Capture frames at bit centres, LSB first
  initial forever begin
    @(negedge serial_transmit_pin);
    repeat (bit_len / 2) @(posedge mclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_len) @(posedge mclk);
      got[i] = serial_transmit_pin;
    end
    repeat (bit_len) @(posedge mclk);
    got_cnt++;
  end
endmodule

/* File: bench/tb_su_uart.sv */
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  end \
end
module tb_su_uart;
  timeunit 1ns;
  timeprecision 100ps;
  import su_pkg::*;
  logic       mclk;
  logic       rstn;
  su_cpu_s    cpu;
  su_tmr_s    tmr;
  logic       ext_osc_clk;
  logic       serial_receive_pin;
  logic       serial_transmit_pin;
  logic [7:0] rdata;
  logic       irq_req;
  logic       tx_ready;
  int         error_cnt = 0;
  int         compares = 0;
  int         nw;
  logic [2:0] csel [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  int         blen [4] = '{16, 48, 192, 128};
  su_uart dut_u (.mclk, .rstn, .cpu, .tmr, .ext_osc_clk, .serial_receive_pin,
    .serial_transmit_pin, .rdata, .irq_req, .tx_ready);
  su_remote u_rem (.mclk, .serial_transmit_pin, .serial_receive_pin);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    ext_osc_clk = 1'b0;
    forever #10 ext_osc_clk = ~ext_osc_clk;
  end
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 cpu = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    #1 cpu.wr = 1'b0;
  endtask
  // Register read, compared once read data has settled
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    #1 cpu = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    #1 cpu.rd = 1'b0;
    @(posedge mclk);
    #1 `CHK(rdata, e)
  endtask
  task automatic rx(input logic [9:0] v, input int n);
    u_rem.send(v, n);
    repeat (8) @(posedge mclk);
  endtask
  task automatic wait_tx(input int n);
    for (int i = 0; i < 6000 && u_rem.got_cnt < n; i++) @(posedge mclk);
    if (u_rem.got_cnt < n) error_cnt++;
    #1;
  endtask
  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #150000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rstn = 1'b0;
    cpu = '0;
    tmr = '{run: 1'b1, clk_sel: 3'h0, reload: 8'hfe};
    repeat (2) @(posedge mclk);
    #1 rstn = 1'b1;
    rdc(8'h98, 8'h40);
    rdc(8'h5a, 8'h00);
    wr(8'h98, 8'h10);
    wr(8'h99, 8'ha5);
    wait_tx(1);
    `CHK(u_rem.got[7:0], 8'ha5)
    rdc(8'h98, 8'h52);
    repeat (20) @(posedge mclk);
    `CHK(irq_req, 1'b1)
    wr(8'h98, 8'h10);
    rx(10'h13c, 8);
    rdc(8'h98, 8'h55);
    rdc(8'h99, 8'h3c);
    rx(10'h177, 8);
    rdc(8'h99, 8'h3c);
    wr(8'h98, 8'h30);
    rx(10'h011, 8);
    rdc(8'h98, 8'h70);
    rdc(8'h99, 8'h3c);
    wr(8'h98, 8'hb8);
    u_rem.nine = 1'b1;
    wr(8'h99, 8'h5a);
    wait_tx(2);
    `CHK(u_rem.got, 9'h15a)
    rx(10'h2c3, 9);
    rdc(8'h98, 8'hfa);
    rx(10'h3c3, 9);
    rdc(8'h98, 8'hff);
    rdc(8'h99, 8'hc3);
    wr(8'h98, 8'h98);
    rx(10'h255, 9);
    rdc(8'h98, 8'hd9);
    rdc(8'h99, 8'h55);
    wr(8'h98, 8'h00);
    u_rem.nine = 1'b0;
    rx(10'h1aa, 8);
    rdc(8'h98, 8'h40);
    rdc(8'h99, 8'h55);
    nw = 0;
    while (nw < 40 && tx_ready === 1'b1) begin
      wr(8'h99, nw[7:0]);
      nw++;
    end
    `CHK(tx_ready, 1'b0)
    wait_tx(2 + nw);
    `CHK(u_rem.got[7:0], nw[7:0] - 8'h01)
    `CHK(tx_ready, 1'b1)
    // Stopped timer holds a written byte back
    tmr.run = 1'b0;
    wr(8'h99, 8'hc6);
    repeat (100) @(posedge mclk);
    `CHK(u_rem.got_cnt, 2 + nw)
    `CHK(serial_transmit_pin, 1'b1)
    tmr.run = 1'b1;
    wait_tx(3 + nw);
    `CHK(u_rem.got[7:0], 8'hc6)
    // Every slower timer source, one byte each way
    wr(8'h98, 8'h10);
    for (int k = 0; k < 4; k++) begin
      tmr.clk_sel = csel[k];
      u_rem.bit_len = blen[k];
      wr(8'h99, 8'h61 + k[7:0]);
      wait_tx(4 + nw + k);
      `CHK(u_rem.got[7:0], 8'h61 + k[7:0])
      rx({2'b01, 8'h9e - k[7:0]}, 8);
      rdc(8'h98, 8'h57);
      rdc(8'h99, 8'h9e - k[7:0]);
      wr(8'h98, 8'h10);
    end
    report_and_stop();
  end
endmodule
